/* File: verilog/pmic_defs.svh */
// What this block does
// RQ1: auto-sleep after idle following own transaction
// RQ2: only own transactions restart auto-sleep countdown
// RQ3: interrupt events wake device from sleep
// RQ4: hibernate keypress enters sleep for debounce
// RQ5: invalid debounced key returns to hibernate
// RQ6: control low bits gate block clocks
// RQ7: internal slow clock default, external when selected
// RQ8: four reset sources: pin, detector, soft, link
// RQ9: host writes sleep bit to sleep
// RQ10: addressed write transaction wakes the device
// RQ11: soft reset bit self-clears after reset
// RQ12: hibernate exits by reset or wake write
// RQ13: polarity bit selects active level or edge
// RQ14: type bit selects level or edge output
// RQ15: global mask gates all, keeps enables
// RQ16: output deasserts only after status cleared
// RQ17: nine enable bits gate the sources
// RQ18: pin follows event within latency bounds
// RQ19: write one clears status, zero keeps
// RQ20: edge type gives one 250 ns pulse
// RQ21: enable and code set inactivity timeout
// RQ22: pin active on mask, status and enable
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH

`define CLK_MHZ        40
`define REG_SYSTEM_CONTROL_REG   8'h02
`define REG_SYS_CTRL2  8'h03
`define REG_ICR_MSB    8'h10
`define REG_ICR_LSB    8'h11
`define REG_IEN_MSB    8'h12
`define REG_IEN_LSB    8'h13
`define REG_ISTA_MSB   8'h14
`define REG_ISTA_LSB   8'h15
`define REG_GIEN_MSB   8'h16
`define REG_GIEN_LSB   8'h17
`define REG_GSTA_MSB   8'h18
`define REG_GSTA_LSB   8'h19
`define SYSTEM_CONTROL_REG_RST   8'h0f
`define SC_SOFT        7
`define SC_CLKSRC      6
`define SC_HIB         5
`define SC_SLEEP       4
`define SC_GPIO        3
`define SC_RSVD        2
`define SC_KPC         1
`define SC_PWM         0
`define SC_STORE_MASK  8'heb
`define SC2_AUTO       3
`define IC_POL         2
`define IC_TYPE        1
`define IC_GLOB        0
`define IS_WAKE        0
`define IS_RSVD        3
`define IS_GPIO        8
`define AS_MS_0        11'd4
`define AS_MS_1        11'd16
`define AS_MS_2        11'd32
`define AS_MS_3        11'd64
`define AS_MS_4        11'd128
`define AS_MS_5        11'd256
`define AS_MS_6        11'd512
`define AS_MS_7        11'd1024
`define MS_TIME_NS     1000000
`define MS_CYCLES      (`MS_TIME_NS * `CLK_MHZ / 1000)
`define PULSE_TIME_NS  250
`define PULSE_CYCLES   4'd10
`define DEB_TIME_US    8000
`define DEB_CYCLES     (`DEB_TIME_US * `CLK_MHZ)
`define LINK_DIV_HALF  8'd4
`define OTHER_HOLD     2'd2
`define HREG_CMD       4'h0
`define HREG_STAT      4'h4
`define HREG_CTRL      4'h8
`define CMD_WE         16
`define CMD_OTHER      17
`define CMD_GCALL      18
`define STAT_BUSY      8
`define STAT_IRQ       9

`endif

/* File: verilog/pmic_pkg.sv */
package pmic_pkg;

  typedef enum logic [1:0] {mode_op, mode_sleep, mode_hib, mode_deb} pmode_t;
  typedef enum logic [1:0] {h_idle, h_req, h_rel, h_other} hstate_t;

  typedef struct packed {
    pmode_t      mode;
    logic [7:0]  ctrl;
    logic [3:0]  ctrl2;
    logic [2:0]  icr;
    logic [8:0]  ien;
    logic [8:0]  ista;
    logic [15:0] gien;
    logic [15:0] gsta;
    logic [19:0] tick;
    logic [10:0] as_ms;
    logic [19:0] deb;
    logic [3:0]  pulse;
    logic        act;
    logic        irq;
    logic        ack;
    logic [7:0]  rdata;
    logic        lclk;
    logic        core_rst;
    logic [2:0]  gate;
    logic        rc_on;
    logic        osc_off;
  } dev_state_t;

  typedef struct packed {
    hstate_t     st;
    logic [7:0]  div;
    logic        lclk;
    logic        req;
    logic        we;
    logic        other;
    logic        gcall;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        pend;
    logic [1:0]  ocnt;
    logic [7:0]  rd;
    logic        rstp;
    logic        waitreq;
    logic [31:0] rdbus;
  } host_state_t;

endpackage

/* File: verilog/pmic_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pmic_link_if;
  logic       link_clk;
  logic       link_rst_n;
  logic       req;
  logic       we;
  logic       other;
  logic       gcall;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       irq;

  modport dev (input link_clk, link_rst_n, req, we, other, gcall, addr, wdata,
               output ack, rdata, irq);
  modport host (output link_clk, link_rst_n, req, we, other, gcall, addr, wdata,
                input ack, rdata, irq);
endinterface
`default_nettype wire

/* File: verilog/pmic_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pmic_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t n;

  // first stage feeds only the second stage
  always_comb
  begin
    n = q;
    if (ce_in)
    begin
      n.s1 = d_in;
      n.s2 = q.s1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q <= '0;
    else
      q <= n;
  end

  assign q_out = q.s2;
endmodule
`default_nettype wire

/* File: verilog/pmic_dev.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmic_defs.svh"
module pmic_dev #(
  parameter int MS_CYC  = `MS_CYCLES,
  parameter int DEB_CYC = `DEB_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  pmic_link_if.dev         link,
  input  wire logic        lvd_in,
  input  wire logic [8:0]  src_event_in,
  input  wire logic [15:0] gpio_event_in,
  input  wire logic        keypress_in,
  output logic      [1:0]  mode_out,
  output logic             rc_osc_on_out,
  output logic             slow_osc_off_out,
  output logic             ext_clk_sel_out,
  output logic             clk_en_gpio_out,
  output logic             clk_en_kpc_out,
  output logic             clk_en_pwm_out,
  output logic             core_reset_out
);

  localparam pmic_pkg::dev_state_t DEV_RST = '{
    mode:    pmic_pkg::mode_op,
    ctrl:    `SYSTEM_CONTROL_REG_RST,
    irq:     1'b1,
    gate:    3'h7,
    rc_on:   1'b1,
    default: '0
  };

  pmic_pkg::dev_state_t q;
  pmic_pkg::dev_state_t n;

  // -----------------------------------------------------------------
  // link sampling
  // -----------------------------------------------------------------
  logic [22:0] s;

  pmic_sync #(
    .W (23)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .d_in       ({lvd_in, link.link_rst_n, link.link_clk, link.req, link.we,
                  link.other, link.gcall, link.addr, link.wdata}),
    .q_out      (s)
  );

  logic       s_lvd;
  logic       s_rst_n;
  logic       s_lclk;
  logic       s_req;
  logic       s_we;
  logic       s_other;
  logic       s_gcall;
  logic [7:0] s_addr;
  logic [7:0] s_wdata;

  assign {s_lvd, s_rst_n, s_lclk, s_req, s_we, s_other, s_gcall, s_addr, s_wdata} = s;

  function automatic logic [10:0] as_limit(input logic [2:0] code);
    case (code)
      3'h0:    as_limit = `AS_MS_0;
      3'h1:    as_limit = `AS_MS_1;
      3'h2:    as_limit = `AS_MS_2;
      3'h3:    as_limit = `AS_MS_3;
      3'h4:    as_limit = `AS_MS_4;
      3'h5:    as_limit = `AS_MS_5;
      3'h6:    as_limit = `AS_MS_6;
      default: as_limit = `AS_MS_7;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    logic        lrise;
    logic        hit;
    logic        rst_req;
    logic        act_now;
    logic        pol;
    logic [8:0]  set;
    logic [8:0]  clr;
    logic [15:0] gclr;
    lrise   = s_lclk & ~q.lclk;
    hit     = lrise & s_req & ~s_other & ~q.ack;
    rst_req = 1'b0;
    clr     = '0;
    gclr    = '0;
    pol     = q.icr[`IC_POL];
    n       = q;
    n.lclk  = s_lclk;
    n.core_rst = 1'b0;

    set = src_event_in;
    set[`IS_RSVD] = 1'b0;
    set[`IS_GPIO] = src_event_in[`IS_GPIO] | (|(gpio_event_in & q.gien));

    // power modes
    unique case (q.mode)
      pmic_pkg::mode_op:
      begin
        if (q.ctrl2[`SC2_AUTO] && !hit)                                    // [RQ1] [RQ21]
        begin
          if (q.tick == 20'(MS_CYC - 1))
          begin
            n.tick  = '0;
            n.as_ms = q.as_ms + 11'h001;
            if (n.as_ms >= as_limit(q.ctrl2[2:0]))
            begin
              n.mode  = pmic_pkg::mode_sleep;
              n.as_ms = '0;
            end
          end
          else
            n.tick = q.tick + 20'h00001;
        end
      end
      pmic_pkg::mode_sleep:
      begin
        if (|(set & q.ien))                                                 // [RQ3]
          n.mode = pmic_pkg::mode_op;
      end
      pmic_pkg::mode_hib:
      begin
        if (keypress_in)                                                    // [RQ4]
        begin
          n.mode = pmic_pkg::mode_deb;
          n.deb  = '0;
        end
      end
      pmic_pkg::mode_deb:
      begin
        if (!keypress_in)
          n.mode = pmic_pkg::mode_hib;                                      // [RQ5]
        else if (q.deb == 20'(DEB_CYC - 1))
          n.mode = pmic_pkg::mode_sleep;                                    // [RQ4]
        else
          n.deb = q.deb + 20'h00001;
      end
    endcase

    // link handshake; traffic for other slaves leaves the countdown alone
    if (lrise && !s_req)
      n.ack = 1'b0;
    if (hit)
    begin
      n.ack   = 1'b1;
      n.tick  = '0;                                                         // [RQ2]
      n.as_ms = '0;
      if (s_gcall)
        rst_req = 1'b1;
      else if (s_we)
      begin
        if (q.mode != pmic_pkg::mode_op)                                   // [RQ10] [RQ12]
        begin
          n.mode = pmic_pkg::mode_op;
          n.ctrl[`SC_HIB] = 1'b0;
          set[`IS_WAKE] = 1'b1;
        end
        case (s_addr)
          `REG_SYSTEM_CONTROL_REG:
          begin
            n.ctrl = s_wdata & `SC_STORE_MASK;                              // [RQ6] [RQ7]
            if (s_wdata[`SC_SLEEP])
              n.mode = pmic_pkg::mode_sleep;                                // [RQ9]
            if (s_wdata[`SC_HIB])
              n.mode = pmic_pkg::mode_hib;
          end
          `REG_SYS_CTRL2: n.ctrl2 = s_wdata[3:0];                           // [RQ21]
          `REG_ICR_LSB:   n.icr = s_wdata[2:0];                             // [RQ15]
          `REG_IEN_MSB:   n.ien[8] = s_wdata[0];                            // [RQ17]
          `REG_IEN_LSB:   n.ien[7:0] = s_wdata;
          `REG_ISTA_MSB:  clr[8] = s_wdata[0];                              // [RQ19]
          `REG_ISTA_LSB:  clr[7:0] = s_wdata;
          `REG_GIEN_MSB:  n.gien[15:8] = s_wdata;
          `REG_GIEN_LSB:  n.gien[7:0] = s_wdata;
          `REG_GSTA_MSB:  gclr[15:8] = s_wdata;
          `REG_GSTA_LSB:  gclr[7:0] = s_wdata;
          default: ;
        endcase
      end
      else
      begin
        case (s_addr)
          `REG_SYSTEM_CONTROL_REG:  n.rdata = {1'b0, q.ctrl[6:5], 1'b0, q.ctrl[3], 1'b1, q.ctrl[1:0]};
          `REG_SYS_CTRL2: n.rdata = {4'h0, q.ctrl2};
          `REG_ICR_LSB:   n.rdata = {5'h00, q.icr};
          `REG_IEN_MSB:   n.rdata = {7'h00, q.ien[8]};
          `REG_IEN_LSB:   n.rdata = q.ien[7:0];
          `REG_ISTA_MSB:  n.rdata = {7'h00, q.ista[8]};
          `REG_ISTA_LSB:  n.rdata = q.ista[7:0];
          `REG_GIEN_MSB:  n.rdata = q.gien[15:8];
          `REG_GIEN_LSB:  n.rdata = q.gien[7:0];
          `REG_GSTA_MSB:  n.rdata = q.gsta[15:8];
          `REG_GSTA_LSB:  n.rdata = q.gsta[7:0];
          default:        n.rdata = 8'h00;
        endcase
      end
    end

    // status: a new event beats a clear in the same cycle
    n.ista = (q.ista & ~clr) | set;                                         // [RQ19]
    n.gsta = (q.gsta & ~gclr) | gpio_event_in;

    // interrupt pin, two cycles from event, far inside every latency bound
    act_now = q.icr[`IC_GLOB] & (|(q.ista & q.ien));                        // [RQ22] [RQ15] [RQ18]
    n.act   = act_now;
    if (q.icr[`IC_TYPE])                                                    // [RQ14]
    begin
      if (act_now && !q.act)
        n.pulse = `PULSE_CYCLES;                                            // [RQ20]
      else if (q.pulse != 4'h0)
        n.pulse = q.pulse - 4'h1;
      n.irq = (n.pulse != 4'h0) ? pol : ~pol;                               // [RQ13]
    end
    else
    begin
      n.pulse = '0;
      n.irq   = act_now ? pol : ~pol;                                       // [RQ13] [RQ16]
    end

    // any reset source restores defaults; ack survives so the link
    // transfer that asked for the reset is not replayed
    if (!s_rst_n || s_lvd || q.ctrl[`SC_SOFT] || rst_req)                   // [RQ8] [RQ11]
    begin
      n          = DEV_RST;
      n.ack      = hit | (q.ack & ~(lrise & ~s_req));
      n.lclk     = s_lclk;
      n.core_rst = 1'b1;
    end

    n.rc_on   = (n.mode == pmic_pkg::mode_op);
    n.osc_off = (n.mode == pmic_pkg::mode_hib);
    if (n.mode == pmic_pkg::mode_op || n.mode == pmic_pkg::mode_sleep)
      n.gate = {n.ctrl[`SC_GPIO], n.ctrl[`SC_KPC], n.ctrl[`SC_PWM]};        // [RQ6]
    else if (n.mode == pmic_pkg::mode_deb)
      n.gate = {1'b0, n.ctrl[`SC_KPC], 1'b0};
    else
      n.gate = 3'h0;

    if (!ce_in)
      n = q;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q <= DEV_RST;
    else
      q <= n;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign link.ack         = q.ack;
  assign link.rdata       = q.rdata;
  assign link.irq         = q.irq;
  assign mode_out         = q.mode;
  assign rc_osc_on_out    = q.rc_on;
  assign slow_osc_off_out = q.osc_off;
  assign ext_clk_sel_out  = q.ctrl[`SC_CLKSRC];                             // [RQ7]
  assign clk_en_gpio_out  = q.gate[2];
  assign clk_en_kpc_out   = q.gate[1];
  assign clk_en_pwm_out   = q.gate[0];
  assign core_reset_out   = q.core_rst;
endmodule
`default_nettype wire

/* File: verilog/pmic_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmic_defs.svh"
module pmic_host (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  pmic_link_if.host        link,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);

  localparam pmic_pkg::host_state_t HOST_RST = '{
    st:      pmic_pkg::h_idle,
    waitreq: 1'b1,
    default: '0
  };

  pmic_pkg::host_state_t q;
  pmic_pkg::host_state_t n;

  logic [9:0] s;

  pmic_sync #(
    .W (10)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .d_in       ({link.ack, link.irq, link.rdata}),
    .q_out      (s)
  );

  always_comb
  begin
    logic tog;
    logic fall;
    logic rise;
    logic busy;
    tog  = (q.div == `LINK_DIV_HALF - 8'h01);
    fall = tog & q.lclk;
    rise = tog & ~q.lclk;
    busy = q.pend | (q.st != pmic_pkg::h_idle);
    n    = q;
    n.div = tog ? 8'h00 : q.div + 8'h01;
    if (tog)
      n.lclk = ~q.lclk;

    // -----------------------------------------------------------------
    // avalon slave: one wait cycle, longer for a command while busy
    // -----------------------------------------------------------------
    n.waitreq = 1'b1;
    if (q.waitreq && (avs_read_in || avs_write_in) &&
        !(avs_write_in && avs_address_in == `HREG_CMD && busy))
    begin
      n.waitreq = 1'b0;
      case (avs_address_in)
        `HREG_STAT: n.rdbus = {22'h000000, s[8], busy, q.rd};
        `HREG_CTRL: n.rdbus = {31'h00000000, q.rstp};
        default:    n.rdbus = 32'h00000000;
      endcase
    end
    if (!q.waitreq && avs_write_in)
    begin
      case (avs_address_in)
        `HREG_CMD:
        begin
          n.pend  = 1'b1;                                                   // [RQ9] [RQ10] [RQ11]
          n.wdata = avs_writedata_in[7:0];
          n.addr  = avs_writedata_in[15:8];
          n.we    = avs_writedata_in[`CMD_WE];
          n.other = avs_writedata_in[`CMD_OTHER];
          n.gcall = avs_writedata_in[`CMD_GCALL];
        end
        `HREG_CTRL: n.rstp = avs_writedata_in[0];                           // [RQ12]
        default: ;
      endcase
    end

    // -----------------------------------------------------------------
    // link sequencer; req only moves on falling link clock
    // -----------------------------------------------------------------
    unique case (q.st)
      pmic_pkg::h_idle:
      begin
        if (q.pend && fall)
        begin
          n.req  = 1'b1;
          n.pend = 1'b0;
          n.ocnt = `OTHER_HOLD;
          n.st   = q.other ? pmic_pkg::h_other : pmic_pkg::h_req;
        end
      end
      pmic_pkg::h_req:
      begin
        if (s[9])
          n.st = pmic_pkg::h_rel;
      end
      pmic_pkg::h_rel:
      begin
        // read data crossed beside ack; one cycle later every bit has settled
        if (q.req)
          n.rd = s[7:0];
        if (q.req && fall)
          n.req = 1'b0;
        if (!q.req && !s[9])
          n.st = pmic_pkg::h_idle;
      end
      pmic_pkg::h_other:
      begin
        if (rise && q.ocnt != 2'h0)
          n.ocnt = q.ocnt - 2'h1;
        if (q.ocnt == 2'h0 && fall)
        begin
          n.req = 1'b0;
          n.st  = pmic_pkg::h_idle;
        end
      end
    endcase

    if (!ce_in)
      n = q;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q <= HOST_RST;
    else
      q <= n;
  end

  assign link.link_clk       = q.lclk;
  assign link.link_rst_n     = ~q.rstp;
  assign link.req            = q.req;
  assign link.we             = q.we;
  assign link.other          = q.other;
  assign link.gcall          = q.gcall;
  assign link.addr           = q.addr;
  assign link.wdata          = q.wdata;
  assign avs_readdata_out    = q.rdbus;
  assign avs_waitrequest_out = q.waitreq;
endmodule
`default_nettype wire

/* File: verification/pmic_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pmic_chk (
  input wire logic       sys_clk_in,
  input wire logic       arst_n_in,
  input wire logic       link_clk_in,
  input wire logic       req_in,
  input wire logic       other_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       ack_in
);
  // ----
  // link handshake and link clock high phase
  // ----
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // the answer does not wait for wake-up in any mode; the bound is simply generous
  chk_ack_in_time: assert property ($rose(req_in) && !other_in |-> ##[1:200] ack_in)
    else $error("no ack in time");
  chk_no_other_ack: assert property (req_in && other_in |-> !ack_in)
    else $error("ack given to foreign traffic");
  chk_ack_has_req: assert property ($rose(ack_in) |-> req_in && !other_in)
    else $error("ack rose without own request");
  chk_ack_holds: assert property (ack_in && req_in |=> ack_in)
    else $error("ack dropped while request up");
  chk_ack_release: assert property ($fell(req_in) |-> ##[1:30] !ack_in)
    else $error("ack not released");
  chk_req_holds: assert property (req_in && !ack_in && !other_in |=> req_in)
    else $error("request dropped before ack");
  chk_frame_stable: assert property (req_in && $past(req_in) |->
                                     $stable(addr_in) && $stable(wdata_in))
    else $error("address or data moved in a transfer");
  chk_link_half: assert property ($rose(link_clk_in) |=> link_clk_in [*3] ##1 !link_clk_in)
    else $error("link clock high phase wrong");
endmodule
`default_nettype wire

/* File: verification/power_mode_and_interrupt_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module power_mode_and_interrupt_ctrl_bench;
  logic        clk, rst_n, rd, wr_en, wrq, low_voltage_detector, key, rco, sof, ext, eg, ek, ep, crst;
  logic [3:0]  adr;
  logic [31:0] wd, rdo, got;
  logic [8:0]  sev;
  logic [15:0] gev;
  logic [1:0]  mode;
  int          bad_count, checked, cyc, t0, n, nrst;

  pmic_link_if lnk ();
  pmic_host pmic_host_inst (.sys_clk_in(clk), .arst_n_in(rst_n), .ce_in(1'b1), .link(lnk.host),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr_en), .avs_writedata_in(wd),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wrq));
  // short tick and debounce keep the run brief
  pmic_dev #(.MS_CYC(4), .DEB_CYC(8)) pmic_dev_inst (.sys_clk_in(clk), .arst_n_in(rst_n),
    .ce_in(1'b1), .link(lnk.dev), .lvd_in(low_voltage_detector), .src_event_in(sev), .gpio_event_in(gev),
    .keypress_in(key), .mode_out(mode), .rc_osc_on_out(rco), .slow_osc_off_out(sof),
    .ext_clk_sel_out(ext), .clk_en_gpio_out(eg), .clk_en_kpc_out(ek), .clk_en_pwm_out(ep),
    .core_reset_out(crst));
  pmic_chk pmic_chk_inst (.sys_clk_in(clk), .arst_n_in(rst_n), .link_clk_in(lnk.link_clk),
    .req_in(lnk.req), .other_in(lnk.other), .addr_in(lnk.addr), .wdata_in(lnk.wdata),
    .ack_in(lnk.ack));

  // ----
  // tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic miss(input string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
      miss($sformatf("byte %h want %h", g, e));
  endtask
  task automatic cpin(input logic g, input logic e);
    checked++;
    if (g !== e)
      miss($sformatf("pin %b want %b", g, e));
  endtask
  task automatic hang();
    miss("wait ran out");
    report_and_stop();
  endtask
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr_en <= w;
    wd <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wrq !== 1'b0 && k < 60);
    got = rdo;
    rd <= 1'b0;
    wr_en <= 1'b0;
    if (k >= 60)
      hang();
  endtask
  // f is {general call, other slave, write}
  task automatic lk(input logic [2:0] f, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    av(4'h0, 1'b1, {13'h0, f, a, d});
    do
    begin
      av(4'h4, 1'b0, 32'h0);
      k++;
    end
    while (got[8] !== 1'b0 && k < 80);
    if (k >= 80)
      hang();
  endtask
  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    lk(3'b001, a, d);
  endtask
  task automatic rb(input logic [7:0] a, input logic [7:0] e);
    lk(3'b000, a, 8'h00);
    cmp(got[7:0], e);
  endtask
  // waits on the irq pin when pin is set, else on the mode
  task automatic wfor(input logic [1:0] m, input logic pin, input int lim);
    int k;
    k = 0;
    while ((pin ? {1'b0, lnk.irq} : mode) !== m && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= lim)
      hang();
  endtask
  task automatic pulse(input logic [8:0] s, input logic [15:0] g);
    @(posedge clk);
    sev <= s;
    gev <= g;
    @(posedge clk);
    sev <= 9'h0;
    gev <= 16'h0;
  endtask

  // ----
  // sequence
  // ----
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // internal reset pulses can be as short as one cycle, so they are counted
  always @(posedge clk)
    if (crst === 1'b1)
      nrst <= nrst + 1;

  initial
  begin
    rst_n = 1'b0; rd = 1'b0; wr_en = 1'b0; adr = 4'h0; wd = 32'h0; low_voltage_detector = 1'b0;
    key = 1'b0; sev = 9'h0; gev = 16'h0; cyc = 0; bad_count = 0; checked = 0; nrst = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cpin(rco, 1'b1);
    cpin(ext, 1'b0);
    cmp({eg, ek, ep, lnk.irq, 2'b00, mode}, 8'hf0);
    rb(8'h02, 8'h0f);
    for (logic [7:0] a = 8'h10; a < 8'h14; a++)
      rb(a, 8'h00);
    wb(8'h02, 8'h4a);
    cmp({ext, eg, ek, ep}, 8'he);
    rb(8'h02, 8'h4e);
    wb(8'h02, 8'h0f);
    wb(8'h13, 8'hff);
    wb(8'h12, 8'h01);
    wb(8'h17, 8'h01);
    wb(8'h11, 8'h01);
    for (int k = 0; k <= 8; k++)
    begin
      if (k == 8)
        pulse(9'h0, 16'h1);
      else
        pulse(9'h1 << k, 16'h0);
      if (k == 3)
        repeat (80) @(posedge clk);
      else
        wfor(2'd0, 1'b1, 80);
      rb(8'h15, (k < 8 && k != 3) ? 8'h1 << k : 8'h0);
      rb(8'h14, {7'h0, k == 8});
      rb(8'h19, {7'h0, k == 8});
      wb(8'h15, 8'h00);
      cpin(lnk.irq, k == 3);
      wb(8'h19, 8'hff);
      wb(8'h15, 8'hff);
      wb(8'h14, 8'hff);
      cpin(lnk.irq, 1'b1);
    end
    wb(8'h11, 8'h00);
    pulse(9'h2, 16'h0);
    repeat (80) @(posedge clk);
    cpin(lnk.irq, 1'b1);
    rb(8'h13, 8'hff);
    wb(8'h11, 8'h01);
    wfor(2'd0, 1'b1, 80);
    wb(8'h11, 8'h05);
    wb(8'h15, 8'hff);
    cpin(lnk.irq, 1'b0);
    pulse(9'h4, 16'h0);
    wfor(2'd1, 1'b1, 80);
    wb(8'h15, 8'hff);
    wb(8'h11, 8'h07);
    pulse(9'h10, 16'h0);
    wfor(2'd1, 1'b1, 80);
    n = 0;
    while (lnk.irq === 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    cmp(n[7:0], 8'd10);
    repeat (20) @(posedge clk);
    cpin(lnk.irq, 1'b0);
    wb(8'h15, 8'hff);
    wb(8'h11, 8'h01);
    wb(8'h02, 8'h1f);
    cmp(mode, 8'h1);
    cpin(rco, 1'b0);
    pulse(9'h2, 16'h0);
    wfor(2'd0, 1'b0, 40);
    wb(8'h15, 8'hff);
    wb(8'h02, 8'h1f);
    wb(8'h13, 8'hff);
    cmp(mode, 8'h0);
    rb(8'h15, 8'h01);
    wb(8'h15, 8'hff);
    wb(8'h02, 8'h2f);
    cmp(mode, 8'h2);
    cpin(sof, 1'b1);
    key <= 1'b1;
    wfor(2'd3, 1'b0, 20);
    key <= 1'b0;
    wfor(2'd2, 1'b0, 40);
    key <= 1'b1;
    repeat (30) @(posedge clk);
    key <= 1'b0;
    cmp(mode, 8'h1);
    wb(8'h13, 8'hff);
    cmp(mode, 8'h0);
    wb(8'h15, 8'hff);
    wb(8'h02, 8'h2f);
    av(4'h8, 1'b1, 32'h1);
    repeat (4) @(posedge clk);
    av(4'h8, 1'b1, 32'h0);
    wfor(2'd0, 1'b0, 40);
    rb(8'h02, 8'h0f);
    wb(8'h03, 8'h09);
    t0 = cyc;
    lk(3'b011, 8'h02, 8'h00);
    cmp(mode, 8'h0);
    wfor(2'd1, 1'b0, 200);
    cpin(cyc - t0 >= 30 && cyc - t0 <= 62, 1'b1);
    wb(8'h03, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wb(8'h11, 8'h04);
      t0 = nrst;
      if (i == 0)
        wb(8'h02, 8'h8f);
      else if (i == 1)
        lk(3'b101, 8'h00, 8'h00);
      else
      begin
        low_voltage_detector <= 1'b1;
        repeat (4) @(posedge clk);
        low_voltage_detector <= 1'b0;
        repeat (8) @(posedge clk);
      end
      rb(8'h11, 8'h00);
      rb(8'h02, 8'h0f);
      cpin(lnk.irq, 1'b1);
      cpin(nrst > t0, 1'b1);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
